/* dfd_pkg.sv */
// constants shared by the digital input function decoder
package dfd_pkg;

    localparam int NUM_DI_DEFAULT = 8;
    localparam int CODE_W         = 8;
    localparam int MODE_W         = 5;
    localparam int FAULT_W        = 8;
    localparam int ADDR_W         = 8;
    localparam int DATA_W         = 32;

    // input function codes
    localparam logic [CODE_W-1:0] FN_DISABLED        = 8'h00;
    localparam logic [CODE_W-1:0] FN_EMERGENCY_STOP  = 8'h21;
    localparam logic [CODE_W-1:0] FN_REVERSE_LIMIT   = 8'h22;
    localparam logic [CODE_W-1:0] FN_FORWARD_LIMIT   = 8'h23;
    localparam logic [CODE_W-1:0] FN_HOME_SENSOR     = 8'h24;
    localparam logic [CODE_W-1:0] FN_GO_HOME         = 8'h27;
    localparam logic [CODE_W-1:0] FN_POSITION_SOURCE = 8'h2B;
    localparam logic [CODE_W-1:0] FN_CAM             = 8'h36;
    localparam logic [CODE_W-1:0] FN_JOG_FORWARD     = 8'h37;
    localparam logic [CODE_W-1:0] FN_JOG_REVERSE     = 8'h38;
    localparam logic [CODE_W-1:0] FN_EVENT_ONE       = 8'h39;
    localparam logic [CODE_W-1:0] FN_EVENT_TWO       = 8'h3A;
    localparam logic [CODE_W-1:0] FN_EVENT_THREE     = 8'h3B;
    localparam logic [CODE_W-1:0] FN_EVENT_FOUR      = 8'h3C;
    localparam logic [CODE_W-1:0] FN_GEAR_SEL_LO     = 8'h43;
    localparam logic [CODE_W-1:0] FN_GEAR_SEL_HI     = 8'h44;
    localparam logic [CODE_W-1:0] FN_PULSE_INHIBIT   = 8'h45;

    // fault codes, decimal 13..15 as shown on the drive display
    localparam logic [FAULT_W-1:0] FAULT_NONE           = 8'h00;
    localparam logic [FAULT_W-1:0] FAULT_EMERGENCY_STOP = 8'h0D;
    localparam logic [FAULT_W-1:0] FAULT_REVERSE_LIMIT  = 8'h0E;
    localparam logic [FAULT_W-1:0] FAULT_FORWARD_LIMIT  = 8'h0F;

    // control mode setting values
    localparam logic [MODE_W-1:0] MODE_SINGLE_MIN = 5'h0B;
    localparam logic [MODE_W-1:0] MODE_SINGLE_MAX = 5'h11;
    localparam logic [MODE_W-1:0] MODE_DUAL_MIN   = 5'h12;
    localparam logic [MODE_W-1:0] MODE_DUAL_MAX   = 5'h14;
    localparam logic [MODE_W-1:0] MODE_PT         = 5'h0B;
    localparam logic [MODE_W-1:0] MODE_PR         = 5'h0C;
    localparam logic [MODE_W-1:0] MODE_DUAL_POSITION_SOURCE_SWITCH = 5'h14;
    localparam logic [MODE_W-1:0] MODE_RESET      = 5'h0B;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_FUNC_BASE  = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL_MODE  = 8'h20;
    localparam logic [ADDR_W-1:0] REG_LEVELS     = 8'h24;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 8'h2C;
    localparam logic [ADDR_W-1:0] REG_FAULT      = 8'h30;
    localparam logic [ADDR_W-1:0] REG_RAW_INPUTS = 8'h34;

    // interrupt status bits
    localparam int IRQ_EMERGENCY_STOP = 0;
    localparam int IRQ_REVERSE_LIMIT  = 1;
    localparam int IRQ_FORWARD_LIMIT  = 2;
    localparam int IRQ_HOME_SEARCH    = 3;
    localparam int IRQ_GO_HOME        = 4;
    localparam int IRQ_EVENT_TRIGGER  = 5;
    localparam int IRQ_W              = 6;

    // first firmware revision with event triggers three and four
    localparam int MIN_REV_EVENT_34 = 1009;

    typedef enum logic [1:0] {
        DFD_POS_NONE = 2'b00,
        DFD_POS_PT   = 2'b01,
        DFD_POS_PR   = 2'b10
    } dfd_pos_t;

endpackage

/* dfd_di_if.sv */
// synchronised input levels and edges between the sampler and the decoder
interface dfd_di_if #(parameter int NUM_DI = 8);
    logic [NUM_DI-1:0] level;
    logic [NUM_DI-1:0] rise;
    logic [NUM_DI-1:0] fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

/* dfd_input_sync.sv */
// two-flop synchroniser and edge detector for the digital inputs
module dfd_input_sync #(
    parameter int NUM_DI = 8
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [NUM_DI-1:0] pinIn,
    dfd_di_if.src                  di
);
    logic [NUM_DI-1:0] meta;
    logic [NUM_DI-1:0] stable;
    logic [NUM_DI-1:0] prev;

    // meta feeds only stable
    always_ff @(posedge clk) begin
        if (reset) begin
            meta   <= '0;
            stable <= '0;
            prev   <= '0;
        end else begin
            meta   <= pinIn;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign di.level = stable;
    assign di.rise  = stable & ~prev;
    assign di.fall  = ~stable & prev;
endmodule

/* dfd_irq_status.sv */
// sticky event status with write-one-to-clear, mask and level interrupt
module dfd_irq_status #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] eventIn,
    input  wire logic         statusWrite,
    input  wire logic         maskWrite,
    input  wire logic [W-1:0] wrData,
    output logic      [W-1:0] status,
    output logic      [W-1:0] mask,
    output logic              irq
);
    logic [W-1:0] next_status;
    logic [W-1:0] next_mask;

    // a set in the clearing cycle survives
    always_comb begin
        next_status = (statusWrite ? (status & ~wrData) : status) | eventIn;
        next_mask   = maskWrite ? wrData : mask;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            status <= '0;
            mask   <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            mask   <= next_mask;
            irq    <= |(next_status & next_mask);
        end
    end
endmodule

/* dfd_decoder.sv */
// digital input function decoder: top level with register port
// Behaviour
// [RULE1] code 0x21 low raises emergency stop fault 13
// [RULE2] code 0x22 low raises reverse limit fault 14
// [RULE3] code 0x23 low raises forward limit fault 15
// [RULE4] code 0x24 either edge starts home search, PR
// [RULE5] code 0x27 rising edge starts go home, PR
// [RULE6] code 0x36 edges drive cam, PR, variant-gated
// [RULE7] code 0x37 high jogs forward, any mode
// [RULE8] code 0x38 high jogs reverse, any mode
// [RULE9] codes 0x39-0x3C fire events on edges, PR
// [RULE10] events three, four need revision 1009 onward
// [RULE11] codes 0x43/0x44 select gear numerator in PT
// [RULE12] code 0x45 high blocks pulse commands in PT
// [RULE13] integrator wires pulse inhibit to input eight
// [RULE14] code zero disables the input entirely
// [RULE15] modes 11-17 single, 18-20 dual
// [RULE16] code 0x2B switches PT off, PR on
// [RULE17] inputs synchronised; levels follow, edges pulse once
module dfd_decoder #(
    parameter int NUM_DI       = dfd_pkg::NUM_DI_DEFAULT,
    parameter int FIRMWARE_REV = 1009,
    parameter bit HAS_CAM      = 1'b1
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [NUM_DI-1:0]           diPin,
    input  wire logic [dfd_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [dfd_pkg::DATA_W-1:0]  regWrData,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    output logic      [dfd_pkg::DATA_W-1:0]  regRdData,
    output logic                             faultEmergencyStop,
    output logic                             faultReverseLimit,
    output logic                             faultForwardLimit,
    output logic      [dfd_pkg::FAULT_W-1:0] faultCode,
    output logic                             homeSearchStart,
    output logic                             goHomeStart,
    output logic                             camTrigger,
    output logic                             jogForward,
    output logic                             jogReverse,
    output logic      [3:0]                  eventTrigger,
    output logic      [1:0]                  gearNumeratorSel,
    output logic                             pulseInhibit,
    output logic                             internalPositionMode,
    output logic                             pulseTrainPositionMode,
    output logic                             irq
);
    if (NUM_DI < 1 || NUM_DI > 8) begin : g_check
        $error("NUM_DI must lie between 1 and 8");
    end

    localparam bit EVENT_34_PRESENT = (FIRMWARE_REV >= dfd_pkg::MIN_REV_EVENT_34);
    localparam int FUNC_IDX_W       = 3;

    dfd_di_if #(.NUM_DI(NUM_DI)) di ();

    logic [dfd_pkg::CODE_W-1:0] funcAssign [NUM_DI];
    logic [dfd_pkg::MODE_W-1:0] ctrlMode;
    dfd_pkg::dfd_pos_t          posMode;
    logic                       modeValid;
    logic                       modeDual;
    logic                       sourceSwitch;
    logic [dfd_pkg::IRQ_W-1:0]  irqEvents;
    logic [dfd_pkg::IRQ_W-1:0]  irqStatus;
    logic [dfd_pkg::IRQ_W-1:0]  irqMask;
    logic                       irqStatusWrite;
    logic                       irqMaskWrite;
    logic                       funcWrite;
    logic [FUNC_IDX_W-1:0]      funcIdx;

    logic                        next_faultEmergencyStop;
    logic                        next_faultReverseLimit;
    logic                        next_faultForwardLimit;
    logic [dfd_pkg::FAULT_W-1:0] next_faultCode;
    logic                        next_homeSearchStart;
    logic                        next_goHomeStart;
    logic                        next_camTrigger;
    logic                        next_jogForward;
    logic                        next_jogReverse;
    logic [3:0]                  next_eventTrigger;
    logic [1:0]                  next_gearNumeratorSel;
    logic                        next_pulseInhibit;

    dfd_input_sync #(.NUM_DI(NUM_DI)) u_sync (
        .clk   (clk),
        .reset (reset),
        .pinIn (diPin),
        .di    (di.src)
    );

    // true when an input carrying code shows a set bit in vec
    function automatic logic hit(input logic [dfd_pkg::CODE_W-1:0] code, input logic [NUM_DI-1:0] vec);
        logic found;
        found = 1'b0;
        for (int i = 0; i < NUM_DI; i++) begin
            // code zero never matches a function
            if (code != dfd_pkg::FN_DISABLED && funcAssign[i] == code && vec[i]) begin // [RULE14]
                found = 1'b1;
            end
        end
        return found;
    endfunction

    // normally closed contact: fault when an assigned input is open
    function automatic logic openContact(input logic [dfd_pkg::CODE_W-1:0] code);
        return hit(code, ~di.level);
    endfunction

    // register write decode
    always_comb begin
        funcWrite      = regWrite && regAddr[7:5] == dfd_pkg::REG_FUNC_BASE[7:5]
                         && regAddr[1:0] == 2'b00 && int'(regAddr[4:2]) < NUM_DI;
        funcIdx        = regAddr[4:2];
        irqStatusWrite = regWrite && regAddr == dfd_pkg::REG_IRQ_STATUS;
        irqMaskWrite   = regWrite && regAddr == dfd_pkg::REG_IRQ_MASK;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_DI; i++) begin
                funcAssign[i] <= dfd_pkg::FN_DISABLED;
            end
        end else if (funcWrite) begin
            funcAssign[funcIdx] <= regWrData[dfd_pkg::CODE_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlMode <= dfd_pkg::MODE_RESET;
        end else if (regWrite && regAddr == dfd_pkg::REG_CTRL_MODE) begin
            ctrlMode <= regWrData[dfd_pkg::MODE_W-1:0];
        end
    end

    // control mode: PT and PR fix the source, dual POSITION_SOURCE_SWITCH follows the switch input, other modes select none
    always_comb begin
        modeValid    = ctrlMode >= dfd_pkg::MODE_SINGLE_MIN && ctrlMode <= dfd_pkg::MODE_DUAL_MAX; // [RULE15]
        modeDual     = ctrlMode >= dfd_pkg::MODE_DUAL_MIN && ctrlMode <= dfd_pkg::MODE_DUAL_MAX; // [RULE15]
        sourceSwitch = hit(dfd_pkg::FN_POSITION_SOURCE, di.level);
        if (ctrlMode == dfd_pkg::MODE_PT) begin
            posMode = dfd_pkg::DFD_POS_PT;
        end else if (ctrlMode == dfd_pkg::MODE_PR) begin
            posMode = dfd_pkg::DFD_POS_PR;
        end else if (ctrlMode == dfd_pkg::MODE_DUAL_POSITION_SOURCE_SWITCH) begin
            posMode = sourceSwitch ? dfd_pkg::DFD_POS_PR : dfd_pkg::DFD_POS_PT; // [RULE16]
        end else begin
            posMode = dfd_pkg::DFD_POS_NONE;
        end
    end

    // decoded commands; edges come from the synchronised sampler so each lasts one cycle
    always_comb begin
        next_faultEmergencyStop = openContact(dfd_pkg::FN_EMERGENCY_STOP); // [RULE1]
        next_faultReverseLimit  = openContact(dfd_pkg::FN_REVERSE_LIMIT); // [RULE2]
        next_faultForwardLimit  = openContact(dfd_pkg::FN_FORWARD_LIMIT); // [RULE3]
        // emergency stop outranks the travel limits on the fault display
        if (next_faultEmergencyStop) begin
            next_faultCode = dfd_pkg::FAULT_EMERGENCY_STOP; // [RULE1]
        end else if (next_faultReverseLimit) begin
            next_faultCode = dfd_pkg::FAULT_REVERSE_LIMIT; // [RULE2]
        end else if (next_faultForwardLimit) begin
            next_faultCode = dfd_pkg::FAULT_FORWARD_LIMIT; // [RULE3]
        end else begin
            next_faultCode = dfd_pkg::FAULT_NONE;
        end
        next_jogForward = hit(dfd_pkg::FN_JOG_FORWARD, di.level); // [RULE7] [RULE17]
        next_jogReverse = hit(dfd_pkg::FN_JOG_REVERSE, di.level); // [RULE8] [RULE17]
        next_homeSearchStart = 1'b0;
        next_goHomeStart     = 1'b0;
        next_camTrigger      = 1'b0;
        next_eventTrigger    = 4'h0;
        next_gearNumeratorSel = 2'b00;
        next_pulseInhibit     = 1'b0;
        unique case (posMode)
            dfd_pkg::DFD_POS_PR: begin
                next_homeSearchStart = hit(dfd_pkg::FN_HOME_SENSOR, di.rise | di.fall); // [RULE4] [RULE17]
                next_goHomeStart     = hit(dfd_pkg::FN_GO_HOME, di.rise); // [RULE5]
                next_camTrigger      = HAS_CAM && hit(dfd_pkg::FN_CAM, di.rise | di.fall); // [RULE6]
                next_eventTrigger[0] = hit(dfd_pkg::FN_EVENT_ONE, di.rise | di.fall); // [RULE9]
                next_eventTrigger[1] = hit(dfd_pkg::FN_EVENT_TWO, di.rise | di.fall); // [RULE9]
                next_eventTrigger[2] = EVENT_34_PRESENT
                                       && hit(dfd_pkg::FN_EVENT_THREE, di.rise | di.fall); // [RULE9] [RULE10]
                next_eventTrigger[3] = EVENT_34_PRESENT
                                       && hit(dfd_pkg::FN_EVENT_FOUR, di.rise | di.fall); // [RULE9] [RULE10]
            end
            dfd_pkg::DFD_POS_PT: begin
                next_gearNumeratorSel = {hit(dfd_pkg::FN_GEAR_SEL_HI, di.level),
                                         hit(dfd_pkg::FN_GEAR_SEL_LO, di.level)}; // [RULE11]
                // same latency on every input, though input eight is the one the integrator is asked to use
                next_pulseInhibit = hit(dfd_pkg::FN_PULSE_INHIBIT, di.level); // [RULE12] [RULE13]
            end
            dfd_pkg::DFD_POS_NONE: begin
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            faultEmergencyStop <= 1'b0;
            faultReverseLimit  <= 1'b0;
            faultForwardLimit  <= 1'b0;
            faultCode          <= dfd_pkg::FAULT_NONE;
        end else begin
            faultEmergencyStop <= next_faultEmergencyStop;
            faultReverseLimit  <= next_faultReverseLimit;
            faultForwardLimit  <= next_faultForwardLimit;
            faultCode          <= next_faultCode;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            homeSearchStart        <= 1'b0;
            goHomeStart            <= 1'b0;
            camTrigger             <= 1'b0;
            jogForward             <= 1'b0;
            jogReverse             <= 1'b0;
            eventTrigger           <= 4'h0;
            gearNumeratorSel       <= 2'b00;
            pulseInhibit           <= 1'b0;
            internalPositionMode   <= 1'b0;
            pulseTrainPositionMode <= 1'b0;
        end else begin
            homeSearchStart        <= next_homeSearchStart;
            goHomeStart            <= next_goHomeStart;
            camTrigger             <= next_camTrigger;
            jogForward             <= next_jogForward;
            jogReverse             <= next_jogReverse;
            eventTrigger           <= next_eventTrigger;
            gearNumeratorSel       <= next_gearNumeratorSel;
            pulseInhibit           <= next_pulseInhibit;
            internalPositionMode   <= posMode == dfd_pkg::DFD_POS_PR;
            pulseTrainPositionMode <= posMode == dfd_pkg::DFD_POS_PT;
        end
    end

    // faults interrupt on onset only, so a held fault does not refire after clearing
    always_comb begin
        irqEvents                              = '0;
        irqEvents[dfd_pkg::IRQ_EMERGENCY_STOP] = next_faultEmergencyStop & ~faultEmergencyStop;
        irqEvents[dfd_pkg::IRQ_REVERSE_LIMIT]  = next_faultReverseLimit & ~faultReverseLimit;
        irqEvents[dfd_pkg::IRQ_FORWARD_LIMIT]  = next_faultForwardLimit & ~faultForwardLimit;
        irqEvents[dfd_pkg::IRQ_HOME_SEARCH]    = next_homeSearchStart;
        irqEvents[dfd_pkg::IRQ_GO_HOME]        = next_goHomeStart;
        irqEvents[dfd_pkg::IRQ_EVENT_TRIGGER]  = |next_eventTrigger;
    end

    dfd_irq_status #(.W(dfd_pkg::IRQ_W)) u_irq (
        .clk         (clk),
        .reset       (reset),
        .eventIn     (irqEvents),
        .statusWrite (irqStatusWrite),
        .maskWrite   (irqMaskWrite),
        .wrData      (regWrData[dfd_pkg::IRQ_W-1:0]),
        .status      (irqStatus),
        .mask        (irqMask),
        .irq         (irq)
    );

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            regRdData <= '0;
        end else if (!regRead) begin
            regRdData <= '0;
        end else if (regAddr[7:5] == dfd_pkg::REG_FUNC_BASE[7:5] && regAddr[1:0] == 2'b00) begin
            regRdData <= (int'(regAddr[4:2]) < NUM_DI)
                         ? {{(dfd_pkg::DATA_W-dfd_pkg::CODE_W){1'b0}}, funcAssign[regAddr[4:2]]} : '0;
        end else begin
            unique case (regAddr)
                dfd_pkg::REG_CTRL_MODE:  regRdData <= {{(dfd_pkg::DATA_W-dfd_pkg::MODE_W-3){1'b0}},
                                                       modeDual, modeValid, 1'b0, ctrlMode};
                dfd_pkg::REG_LEVELS:     regRdData <= {16'h0000, pulseTrainPositionMode, internalPositionMode,
                                                       pulseInhibit, gearNumeratorSel, jogReverse, jogForward,
                                                       sourceSwitch, 8'h00};
                dfd_pkg::REG_IRQ_STATUS: regRdData <= {{(dfd_pkg::DATA_W-dfd_pkg::IRQ_W){1'b0}}, irqStatus};
                dfd_pkg::REG_IRQ_MASK:   regRdData <= {{(dfd_pkg::DATA_W-dfd_pkg::IRQ_W){1'b0}}, irqMask};
                dfd_pkg::REG_FAULT:      regRdData <= {21'h000000, faultForwardLimit, faultReverseLimit,
                                                       faultEmergencyStop, faultCode};
                dfd_pkg::REG_RAW_INPUTS: regRdData <= {{(dfd_pkg::DATA_W-NUM_DI){1'b0}}, di.level};
                default:                 regRdData <= '0;
            endcase
        end
    end
endmodule

/* dfd_switch_model.sv */
// switch and sensor bank driving the digital input pins
module dfd_switch_model (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic [7:0] want,
    output logic      [7:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] held;
    initial pins = 8'h00;
    // slow contacts lag one more cycle
    always @(posedge clk) begin
        held <= want;
        pins <= slow ? held : want;
    end
endmodule

/* dfd_decoder_sva.sv */
// concurrent checks on the input function decoder ports
module dfd_decoder_sva (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        regRead,
    input wire logic [31:0] regRdData,
    input wire logic        faultEmergencyStop,
    input wire logic        faultReverseLimit,
    input wire logic        faultForwardLimit,
    input wire logic [7:0]  faultCode,
    input wire logic        homeSearchStart,
    input wire logic        goHomeStart,
    input wire logic        camTrigger,
    input wire logic [3:0]  eventTrigger,
    input wire logic [1:0]  gearNumeratorSel,
    input wire logic        pulseInhibit,
    input wire logic        internalPositionMode,
    input wire logic        pulseTrainPositionMode
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    chk_estop_code: assert property (faultEmergencyStop |-> faultCode == 8'h0D)
        else $error("estop fault code wrong");
    chk_reverse_code: assert property (faultReverseLimit && !faultEmergencyStop |-> faultCode == 8'h0E)
        else $error("reverse limit fault code wrong");
    chk_forward_code: assert property (
        faultForwardLimit && !faultEmergencyStop && !faultReverseLimit |-> faultCode == 8'h0F)
        else $error("forward limit fault code wrong");
    chk_no_fault: assert property (
        !(faultEmergencyStop || faultReverseLimit || faultForwardLimit) |-> faultCode == 8'h00)
        else $error("fault code without a fault");
    chk_home_pulse: assert property (goHomeStart |=> !goHomeStart)
        else $error("go home pulse too long");
    chk_mode_excl: assert property (!(internalPositionMode && pulseTrainPositionMode))
        else $error("both position sources active");
    chk_pt_gate: assert property ((gearNumeratorSel != 2'h0 || pulseInhibit) |-> pulseTrainPositionMode)
        else $error("pulse train function outside its mode");
    chk_pr_gate: assert property (
        (homeSearchStart || goHomeStart || camTrigger || eventTrigger != 4'h0) |-> internalPositionMode)
        else $error("edge command outside internal mode");
    chk_read_idle: assert property (!$past(regRead) |-> regRdData == 32'h0)
        else $error("read data outside its cycle");
    cover property (goHomeStart);
    cover property (eventTrigger[3]);
    cover property (faultForwardLimit && !faultReverseLimit);
endmodule
bind dfd_decoder dfd_decoder_sva chk_u (.*);

/* test_dfd_decoder.sv */
// self-checking bench for the digital input function decoder
module test_dfd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] code; logic [4:0] mode; logic pin; logic [17:0] lv;} dfd_lrow_t;
    typedef struct packed {logic [7:0] code; logic [4:0] mode; logic [6:0] sel; logic [1:0] n;} dfd_prow_t;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [7:0]  want = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] regRdData;
    logic [7:0]  pins, faultCode;
    logic [3:0]  eventTrigger;
    logic [1:0]  gear;
    logic        fEs, fRev, fFwd, home, goHome, cam, jogF, jogR, inh, pr, pt, irq;
    logic [6:0]  sel = 7'h00;
    int          n_fail = 0;
    int          n_checks = 0;
    int          cnt = 0;
    int          tot = 0;
    int          c0, t0;
    wire  [17:0] lv = {fEs, fRev, fFwd, faultCode, jogF, jogR, gear, inh, pr, pt};
    wire  [6:0]  pulses = {eventTrigger, cam, goHome, home};
    dfd_lrow_t   lrows[12] = '{'{8'h21, 5'h0B, 1'b0, 18'h20681}, '{8'h22, 5'h0B, 1'b0, 18'h10701},
        '{8'h23, 5'h0B, 1'b0, 18'h08781}, '{8'h21, 5'h0B, 1'b1, 18'h00001}, '{8'h21, 5'h11, 1'b0, 18'h20680},
        '{8'h37, 5'h0C, 1'b1, 18'h00042}, '{8'h38, 5'h0B, 1'b1, 18'h00021}, '{8'h43, 5'h0B, 1'b1, 18'h00009},
        '{8'h44, 5'h0B, 1'b1, 18'h00011}, '{8'h44, 5'h0C, 1'b1, 18'h00002}, '{8'h45, 5'h0C, 1'b1, 18'h00002},
        '{8'h00, 5'h0B, 1'b0, 18'h00001}};
    dfd_prow_t   prows[8] = '{'{8'h24, 5'h0C, 7'h01, 2'h2}, '{8'h24, 5'h0B, 7'h01, 2'h0},
        '{8'h27, 5'h0C, 7'h02, 2'h1}, '{8'h36, 5'h0C, 7'h04, 2'h2}, '{8'h39, 5'h0C, 7'h08, 2'h2},
        '{8'h3A, 5'h0C, 7'h10, 2'h2}, '{8'h3B, 5'h0C, 7'h20, 2'h2}, '{8'h3C, 5'h0C, 7'h40, 2'h2}};
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cnt <= cnt + $countones(pulses & sel);
        tot <= tot + $countones(pulses);
    end
    dfd_switch_model sw_u (.clk(clk), .slow(slow), .want(want), .pins(pins));
    dfd_decoder dut_u (.clk(clk), .reset(reset), .diPin(pins), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .faultEmergencyStop(fEs),
        .faultReverseLimit(fRev), .faultForwardLimit(fFwd), .faultCode(faultCode), .homeSearchStart(home),
        .goHomeStart(goHome), .camTrigger(cam), .jogForward(jogF), .jogReverse(jogR), .eventTrigger(eventTrigger),
        .gearNumeratorSel(gear), .pulseInhibit(inh), .internalPositionMode(pr), .pulseTrainPositionMode(pt),
        .irq(irq));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // sync, output reg, slow contacts
    task automatic settle();
        repeat (7) @(posedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, string what);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(what, e, regRdData);
        @(posedge clk);
    endtask
    task automatic blip();
        want[0] <= 1'b1;
        settle();
        want[0] <= 1'b0;
        settle();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk);
        chk("reset levels", 32'h0, 32'(lv));
        reset <= 1'b0;
        rd(8'h20, 32'h4B, "mode after reset");
        foreach (lrows[i]) begin
            wr(8'h00, 32'(lrows[i].code));
            wr(8'h20, 32'(lrows[i].mode));
            want <= {7'h00, lrows[i].pin};
            settle();
            chk("levels", 32'(lrows[i].lv), 32'(lv));
        end
        $display("test levels done");
        slow <= 1'b1;
        foreach (prows[i]) begin
            want <= 8'h00;
            settle();
            wr(8'h00, 32'(prows[i].code));
            wr(8'h20, 32'(prows[i].mode));
            settle();
            sel <= prows[i].sel;
            c0 = cnt;
            t0 = tot;
            blip();
            chk("pulses", 32'(prows[i].n), 32'(cnt - c0));
            chk("all pulses", 32'(prows[i].n), 32'(tot - t0));
        end
        slow <= 1'b0;
        $display("test pulses done");
        wr(8'h20, 32'h14);
        rd(8'h20, 32'hD4, "dual mode");
        wr(8'h20, 32'h11);
        rd(8'h20, 32'h51, "single mode");
        wr(8'h20, 32'h15);
        rd(8'h20, 32'h15, "bad mode");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h2B);
        wr(8'h20, 32'h14);
        settle();
        chk("source low", 32'h1, 32'(lv));
        want <= 8'h02;
        settle();
        chk("source high", 32'h2, 32'(lv));
        $display("test modes done");
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h27);
        wr(8'h20, 32'h0C);
        want <= 8'h00;
        settle();
        wr(8'h28, 32'h3F);
        wr(8'h2C, 32'h10);
        blip();
        chk("irq set", 32'h1, 32'(irq));
        rd(8'h28, 32'h10, "status");
        wr(8'h28, 32'h10);
        @(posedge clk);
        chk("irq clear", 32'h0, 32'(irq));
        wr(8'h2C, 32'h0);
        blip();
        chk("irq masked", 32'h0, 32'(irq));
        rd(8'h28, 32'h10, "masked status");
        wr(8'h40, 32'hFF);
        rd(8'h40, 32'h0, "unmapped");
        rd(8'h00, 32'h27, "slot readback");
        $display("test registers done");
        wr(8'h1C, 32'h45);
        wr(8'h20, 32'h0B);
        want <= 8'h80;
        settle();
        chk("inhibit on eight", 32'h5, 32'(lv));
        rd(8'h24, 32'hA000, "levels reg");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(8'h1C, 32'h0, "slot after reset");
        rd(8'h20, 32'h4B, "mode after reset");
        $display("test reset done");
        wrap_up();
    end
endmodule
